// ==== hdl/apm_defines.svh ====
// Purpose: Timing counts, pin indices and fixed values of the audio pin mux.
// Assumes: Core clock of 10 MHz.
// Notes:   Counts above 4096 cycles are also top-level parameters.
`ifndef APM_DEFINES_SVH
`define APM_DEFINES_SVH

// Core clock rate and the frame sync silence that resets the chip
`define APM_CORE_MHZ       10
`define APM_SYNC_LOSS_US   1000

// Mic clock: 64 periods per frame, so 128 half periods
`define APM_MIC_STEP       16'h0080

// Subordinate node bit clock: half period in core cycles less one, last bit of frame
`define APM_SUB_BCLK_HALF  3'h1
`define APM_SUB_FRAME_LAST 8'hFF

// Core cycles after reset release before straps are sampled
`define APM_STRAP_SETTLE   2'h3

// Bit positions of the general-purpose vectors
`define APM_GP_STRAP_B     0
`define APM_GP_TX_A        1
`define APM_GP_TX_B        2
`define APM_GP_RX_A        3

// Bit positions of the synchronised input vector
`define APM_SY_STRAP_A     0
`define APM_SY_STRAP_B     1
`define APM_SY_TX_A        2
`define APM_SY_TX_B        3
`define APM_SY_RX_A        4
`define APM_SY_SUPPLY      5
`define APM_SY_FRAME       6
`define APM_SY_WIDTH       7

`endif

// ==== hdl/apm_pkg.sv ====
// Purpose: Types of the audio pin mux.
// Assumes: Constants come from apm_defines.svh.
// Notes:   None.
package apm_pkg;

  typedef enum logic [1:0] {
    APM_HOLD   = 2'h0,
    APM_WAIT   = 2'h1,
    APM_ACTIVE = 2'h3,
    APM_LOST   = 2'h2
  } apm_state_t;

  typedef struct packed {
    logic prev;
    logic tgl;
  } apm_link_t;

  typedef struct packed {
    apm_state_t  st;
    logic [1:0]  strap_cnt;
    logic        strap_done;
    logic [1:0]  addr_sel;
    logic        tgl_prev;
    logic [15:0] quiet_cnt;
    logic [15:0] period;
    logic        period_ok;
    logic [15:0] mic_acc;
    logic        mic_clk;
    logic [3:0]  aux_cnt;
    logic        aux_clk;
    logic [2:0]  sub_div;
    logic [7:0]  sub_bit;
    logic        sub_bclk;
    logic        sub_frame;
    logic        strap_b_drv;
    logic        strap_b_oe;
    logic        bclk_drv;
    logic        bclk_oe;
    logic        sync_drv;
    logic        sync_oe;
    logic        tx_a_drv;
    logic        tx_a_oe;
    logic        tx_b_drv;
    logic        tx_b_oe;
    logic        rx_a_drv;
    logic        rx_a_oe;
    logic [3:0]  gpio_lvl;
    logic        rx_a_bit;
    logic        rx_b_bit;
    logic        mic_bit;
    logic        mic_clk_out;
    logic        chip_reset;
  } apm_core_t;

endpackage : apm_pkg

// ==== hdl/apm_link_if.sv ====
// Purpose: Carries the frame toggle from the link domain to the core.
// Assumes: The toggle is re-synchronised on the core side.
// Notes:   None.
`timescale 1ns/1ns
interface apm_link_if;
  logic frame_tgl;
  modport link_side (output frame_tgl);
  modport core_side (input frame_tgl);
endinterface : apm_link_if

// ==== hdl/apm_sync2.sv ====
// Purpose: Two-flop synchroniser for a vector of independent levels.
// Assumes: Each bit is a slow level or a toggle.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
module apm_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } apm_sync_t;

  apm_sync_t st_q;
  apm_sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule : apm_sync2

// ==== hdl/apm_link_frame.sv ====
// Purpose: Detects frame sync rising edges on the host bit clock.
// Assumes: The bit clock may stop between frames.
// Notes:   Each frame flips a toggle that the core synchronises.
`timescale 1ns/1ns
module apm_link_frame
  import apm_pkg::*;
(
  input  wire logic  link_clk,
  input  wire logic  rst_n,
  input  wire logic  sync_lvl,
  apm_link_if.link_side lk
);
  logic      sync_s;
  apm_link_t st_q;
  apm_link_t st_d;

  apm_sync2 #(.W(1)) u_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .ce    (1'b1),
    .d     (sync_lvl),
    .q     (sync_s)
  );

  always_comb begin
    st_d      = st_q;
    st_d.prev = sync_s;
    if (sync_s && !st_q.prev) begin
      st_d.tgl = !st_q.tgl;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lk.frame_tgl = st_q.tgl;
endmodule : apm_link_frame

// ==== hdl/apm_pin_mux.sv ====
// Purpose: Function selection for the strap, clock, frame and serial pins.
// Assumes: link_clk is the host bit clock on a main node.
// Notes:   Pins stay undriven outside the active state.
`timescale 1ns/1ns
`include "apm_defines.svh"
module apm_pin_mux
  import apm_pkg::*;
#(
  parameter logic [15:0] SYNC_LOSS_CYC = 16'(`APM_SYNC_LOSS_US * `APM_CORE_MHZ)
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       core_ce,
  input  wire logic       link_clk,
  input  wire logic       supply_low,
  input  wire logic       addr_strap_a_gpio_lvl,
  input  wire logic       addr_strap_b_gpio_lvl,
  output logic            addr_strap_b_gpio_drv,
  output logic            addr_strap_b_gpio_oe,
  output logic            bclk_pin_drv,
  output logic            bclk_pin_oe,
  input  wire logic       sync_pin_lvl,
  output logic            sync_pin_drv,
  output logic            sync_pin_oe,
  input  wire logic       serial_tx_a_pin_lvl,
  output logic            serial_tx_a_pin_drv,
  output logic            serial_tx_a_pin_oe,
  input  wire logic       serial_tx_b_pin_lvl,
  output logic            serial_tx_b_pin_drv,
  output logic            serial_tx_b_pin_oe,
  input  wire logic       serial_rx_a_pin_lvl,
  output logic            serial_rx_a_pin_drv,
  output logic            serial_rx_a_pin_oe,
  input  wire logic       node_is_sub,
  input  wire logic       cfg_load,
  input  wire logic       tx_a_en,
  input  wire logic       tx_b_en,
  input  wire logic       rx_b_alt_en,
  input  wire logic       rx_a_en,
  input  wire logic       mic_in_en,
  input  wire logic       bclk_mic_sel,
  input  wire logic       clkout_b_en,
  input  wire logic [3:0] clkout_b_half,
  input  wire logic [3:0] gpio_oe,
  input  wire logic [3:0] gpio_out,
  input  wire logic       serial_tx_a,
  input  wire logic       serial_tx_b,
  output logic [1:0]      i2c_addr_sel,
  output logic            chip_reset,
  output logic [3:0]      gpio_in,
  output logic            serial_rx_a,
  output logic            serial_rx_b,
  output logic            mic_stream_in_a,
  output logic            mic_bit_clock_out
);
  apm_link_if lk ();

  logic [`APM_SY_WIDTH-1:0] raw;
  logic [`APM_SY_WIDTH-1:0] syn;
  logic [16:0]              acc_sum;
  logic                     frame_evt;
  logic                     active;
  logic                     mic_run;
  apm_core_t                st_q;
  apm_core_t                st_d;

  apm_link_frame u_link (
    .link_clk (link_clk),
    .rst_n    (rst_n),
    .sync_lvl (sync_pin_lvl),
    .lk       (lk.link_side)
  );

  assign raw = {lk.frame_tgl, supply_low, serial_rx_a_pin_lvl, serial_tx_b_pin_lvl,
                serial_tx_a_pin_lvl, addr_strap_b_gpio_lvl, addr_strap_a_gpio_lvl};

  apm_sync2 #(.W(`APM_SY_WIDTH)) u_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .ce    (core_ce),
    .d     (raw),
    .q     (syn)
  );

  assign active  = (st_q.st == APM_ACTIVE);
  assign mic_run = active && mic_in_en && st_q.period_ok;
  assign acc_sum = {1'b0, st_q.mic_acc} + {1'b0, `APM_MIC_STEP};
  // Host frames on a main node, own generator on a subordinate node
  assign frame_evt = node_is_sub ? st_q.sub_frame
                                 : (syn[`APM_SY_FRAME] != st_q.tgl_prev);

  always_comb begin
    st_d           = st_q;
    st_d.tgl_prev  = syn[`APM_SY_FRAME];
    st_d.sub_frame = 1'b0;

    // Strap capture once the synchronisers hold settled levels
    if (!st_q.strap_done) begin
      if (st_q.strap_cnt == `APM_STRAP_SETTLE) begin
        st_d.strap_done = 1'b1;
        st_d.addr_sel   = {syn[`APM_SY_STRAP_B], syn[`APM_SY_STRAP_A]};
      end else begin
        st_d.strap_cnt = st_q.strap_cnt + 2'h1;
      end
    end

    // Frame period measurement and silence watch
    if (frame_evt) begin
      st_d.quiet_cnt = '0;
      st_d.period    = st_q.quiet_cnt + 16'h0001;
      st_d.period_ok = ((st_q.quiet_cnt + 16'h0001) >= `APM_MIC_STEP);
    end else if (st_q.quiet_cnt != 16'hFFFF) begin
      st_d.quiet_cnt = st_q.quiet_cnt + 16'h0001;
    end

    // Node state
    case (st_q.st)
      APM_HOLD: begin
        if (st_q.strap_done) begin
          st_d.st = APM_WAIT;
        end
      end
      APM_WAIT: begin
        if (cfg_load) begin
          st_d.st = APM_ACTIVE;
        end
      end
      APM_ACTIVE: begin
        if (!node_is_sub && st_q.quiet_cnt >= SYNC_LOSS_CYC) begin
          st_d.st = APM_LOST;
        end
      end
      APM_LOST: begin
        if (frame_evt) begin
          st_d.st = APM_WAIT;
        end
      end
      default: begin
        st_d.st = APM_HOLD;
      end
    endcase
    if (syn[`APM_SY_SUPPLY]) begin
      st_d.st = APM_HOLD;
    end
    st_d.chip_reset = (st_d.st == APM_HOLD) || (st_d.st == APM_LOST);

    // Mic clock: 128 edges spread over each measured frame
    if (mic_run) begin
      if (acc_sum >= {1'b0, st_d.period}) begin
        st_d.mic_acc = 16'(acc_sum - {1'b0, st_d.period});
        st_d.mic_clk = !st_q.mic_clk;
      end else begin
        st_d.mic_acc = acc_sum[15:0];
      end
    end else begin
      st_d.mic_acc = '0;
      st_d.mic_clk = 1'b0;
    end
    st_d.mic_clk_out = st_q.mic_clk;

    // Auxiliary clock divider on the second strap pin
    if (active && clkout_b_en) begin
      if (st_q.aux_cnt >= clkout_b_half) begin
        st_d.aux_cnt = '0;
        st_d.aux_clk = !st_q.aux_clk;
      end else begin
        st_d.aux_cnt = st_q.aux_cnt + 4'h1;
      end
    end else begin
      st_d.aux_cnt = '0;
      st_d.aux_clk = 1'b0;
    end

    // Subordinate bit clock and frame generator
    if (active && node_is_sub) begin
      if (st_q.sub_div >= `APM_SUB_BCLK_HALF) begin
        st_d.sub_div  = '0;
        st_d.sub_bclk = !st_q.sub_bclk;
        if (st_q.sub_bclk) begin
          st_d.sub_bit = (st_q.sub_bit == `APM_SUB_FRAME_LAST) ? 8'h00 : st_q.sub_bit + 8'h01;
          st_d.sub_frame = (st_q.sub_bit == `APM_SUB_FRAME_LAST);
        end
      end else begin
        st_d.sub_div = st_q.sub_div + 3'h1;
      end
    end else begin
      st_d.sub_div  = '0;
      st_d.sub_bit  = '0;
      st_d.sub_bclk = 1'b0;
    end

    // Pin functions; enabled functions take precedence over general-purpose
    st_d.strap_b_drv = 1'b0;
    st_d.strap_b_oe  = 1'b0;
    st_d.bclk_drv    = 1'b0;
    st_d.bclk_oe     = 1'b0;
    st_d.sync_drv    = 1'b0;
    st_d.sync_oe     = 1'b0;
    st_d.tx_a_drv    = 1'b0;
    st_d.tx_a_oe     = 1'b0;
    st_d.tx_b_drv    = 1'b0;
    st_d.tx_b_oe     = 1'b0;
    st_d.rx_a_drv    = 1'b0;
    st_d.rx_a_oe     = 1'b0;
    if (active) begin
      if (clkout_b_en) begin
        st_d.strap_b_oe  = 1'b1;
        st_d.strap_b_drv = st_q.aux_clk;
      end else begin
        st_d.strap_b_oe  = gpio_oe[`APM_GP_STRAP_B];
        st_d.strap_b_drv = gpio_out[`APM_GP_STRAP_B];
      end
      st_d.bclk_oe  = node_is_sub;
      st_d.bclk_drv = (mic_in_en && bclk_mic_sel) ? st_q.mic_clk : st_q.sub_bclk;
      st_d.sync_oe  = node_is_sub;
      st_d.sync_drv = node_is_sub && (st_q.sub_bit == 8'h00);
      if (tx_a_en) begin
        st_d.tx_a_oe  = 1'b1;
        st_d.tx_a_drv = serial_tx_a;
      end else begin
        st_d.tx_a_oe  = gpio_oe[`APM_GP_TX_A];
        st_d.tx_a_drv = gpio_out[`APM_GP_TX_A];
      end
      if (tx_b_en) begin
        st_d.tx_b_oe  = 1'b1;
        st_d.tx_b_drv = serial_tx_b;
      end else if (!rx_b_alt_en) begin
        st_d.tx_b_oe  = gpio_oe[`APM_GP_TX_B];
        st_d.tx_b_drv = gpio_out[`APM_GP_TX_B];
      end
      if (!rx_a_en && !mic_in_en) begin
        st_d.rx_a_oe  = gpio_oe[`APM_GP_RX_A];
        st_d.rx_a_drv = gpio_out[`APM_GP_RX_A];
      end
    end

    // Receive paths
    st_d.rx_a_bit = active && rx_a_en && syn[`APM_SY_RX_A];
    st_d.mic_bit  = active && mic_in_en && syn[`APM_SY_RX_A];
    st_d.rx_b_bit = active && rx_b_alt_en && !tx_b_en && syn[`APM_SY_TX_B];
    st_d.gpio_lvl = {syn[`APM_SY_RX_A], syn[`APM_SY_TX_B], syn[`APM_SY_TX_A], syn[`APM_SY_STRAP_B]};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (core_ce) begin
      st_q <= st_d;
    end
  end

  assign addr_strap_b_gpio_drv = st_q.strap_b_drv;
  assign addr_strap_b_gpio_oe  = st_q.strap_b_oe;
  assign bclk_pin_drv          = st_q.bclk_drv;
  assign bclk_pin_oe           = st_q.bclk_oe;
  assign sync_pin_drv          = st_q.sync_drv;
  assign sync_pin_oe           = st_q.sync_oe;
  assign serial_tx_a_pin_drv   = st_q.tx_a_drv;
  assign serial_tx_a_pin_oe    = st_q.tx_a_oe;
  assign serial_tx_b_pin_drv   = st_q.tx_b_drv;
  assign serial_tx_b_pin_oe    = st_q.tx_b_oe;
  assign serial_rx_a_pin_drv   = st_q.rx_a_drv;
  assign serial_rx_a_pin_oe    = st_q.rx_a_oe;
  assign i2c_addr_sel          = st_q.addr_sel;
  assign chip_reset            = st_q.chip_reset;
  assign gpio_in               = st_q.gpio_lvl;
  assign serial_rx_a           = st_q.rx_a_bit;
  assign serial_rx_b           = st_q.rx_b_bit;
  assign mic_stream_in_a       = st_q.mic_bit;
  assign mic_bit_clock_out     = st_q.mic_clk_out;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_strap_hold;
    core_ce && st_q.strap_done |=> $stable(i2c_addr_sel);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("address straps changed after capture");

  property p_strap_b_idle;
    core_ce && !active |=> !addr_strap_b_gpio_oe;
  endproperty
  a_strap_b_idle: assert property (p_strap_b_idle) else $error("strap pin driven while not active");

  property p_clkout;
    core_ce && active && clkout_b_en |=> addr_strap_b_gpio_oe && (addr_strap_b_gpio_drv == $past(st_q.aux_clk));
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock output not on strap pin");

  property p_bclk_dir;
    core_ce && active |=> bclk_pin_oe == $past(node_is_sub);
  endproperty
  a_bclk_dir: assert property (p_bclk_dir) else $error("bit clock direction wrong");

  property p_sync_dir;
    core_ce && active |=> sync_pin_oe == $past(node_is_sub);
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("frame sync direction wrong");

  property p_bclk_mic;
    core_ce && active && node_is_sub && mic_in_en && bclk_mic_sel |=> bclk_pin_drv == $past(st_q.mic_clk);
  endproperty
  a_bclk_mic: assert property (p_bclk_mic) else $error("mic clock not on bit clock pin");

  property p_sync_loss;
    core_ce && active && !node_is_sub && !syn[`APM_SY_SUPPLY] && st_q.quiet_cnt >= SYNC_LOSS_CYC
      |=> st_q.st == APM_LOST ##1 !serial_tx_a_pin_oe;
  endproperty
  a_sync_loss: assert property (p_sync_loss) else $error("silent frame sync did not reset");

  property p_tx_a;
    core_ce && active && tx_a_en |=> serial_tx_a_pin_oe && (serial_tx_a_pin_drv == $past(serial_tx_a));
  endproperty
  a_tx_a: assert property (p_tx_a) else $error("first transmit pin not driving data");

  property p_serial_idle;
    core_ce && !active |=> !(serial_tx_a_pin_oe || serial_tx_b_pin_oe || serial_rx_a_pin_oe);
  endproperty
  a_serial_idle: assert property (p_serial_idle) else $error("serial pin driven while not active");

  property p_tx_b_alt;
    core_ce && active && !tx_b_en && rx_b_alt_en |=> !serial_tx_b_pin_oe;
  endproperty
  a_tx_b_alt: assert property (p_tx_b_alt) else $error("second transmit pin driven in receive mode");

  property p_rx_a_in;
    core_ce && active && (rx_a_en || mic_in_en) |=> !serial_rx_a_pin_oe;
  endproperty
  a_rx_a_in: assert property (p_rx_a_in) else $error("receive pin driven while receiving");

  property p_mic_acc;
    mic_run |-> st_q.mic_acc < st_q.period;
  endproperty
  a_mic_acc: assert property (p_mic_acc) else $error("mic accumulator out of range");

  property p_override;
    core_ce && active && tx_b_en && gpio_oe[`APM_GP_TX_B] |=> serial_tx_b_pin_drv == $past(serial_tx_b);
  endproperty
  a_override: assert property (p_override) else $error("general-purpose setting beat transmit");

  c_active: cover property (st_q.st == APM_WAIT ##1 st_q.st == APM_ACTIVE);
  c_lost:   cover property (st_q.st == APM_ACTIVE ##1 st_q.st == APM_LOST);
  c_mic:    cover property (mic_run && $rose(mic_bit_clock_out));
endmodule : apm_pin_mux

// ==== bench/apm_host_model.sv ====
// Purpose: Host processor model driving bit clock and frame sync into a main node.
// Assumes: 64 ns bit clock, frame sync high for the first bit of each frame.
// Notes:   Clock stands still low while run is low.
`timescale 1ns/1ns
module apm_host_model #(
  parameter int BITS = 256
) (
  input  wire logic run,
  output logic      bclk,
  output logic      sync
);
  int bit_cnt;
  initial begin
    bclk    = 1'b0;
    sync    = 1'b0;
    bit_cnt = 0;
    #13;
    forever begin
      #32;
      if (run || bclk) begin
        bclk = ~bclk;
        // Sync moves on the falling edge, away from the sampling edge
        if (!bclk) begin
          sync    = (bit_cnt == 0);
          bit_cnt = (bit_cnt + 1) % BITS;
        end
      end
    end
  end
endmodule : apm_host_model

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench of the audio pin mux.
// Assumes: Sync loss limit shortened to 200 core cycles.
// Notes:   Pin levels resolve from enables; random seed fixed.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic       core_clk = 1'b0, rst_n = 1'b0, supply_low = 1'b0, node_is_sub = 1'b0, cfg_load = 1'b0;
  logic       tx_a_en = 1'b0, tx_b_en = 1'b0, rx_b_alt_en = 1'b0, rx_a_en = 1'b0, mic_in_en = 1'b0;
  logic       bclk_mic_sel = 1'b0, clkout_b_en = 1'b0, serial_tx_a = 1'b0, serial_tx_b = 1'b0;
  logic [3:0] clkout_b_half = 4'h3, gpio_oe = 4'h0, gpio_out = 4'h0, ext = 4'h0;
  logic       strap_a = 1'b0, run = 1'b1;
  int         num_errors = 0, tests_run = 0, seed = 54158, cycles = 0;
  int         mic_edges = 0, bclk_edges = 0, sb_edges = 0;
  wire logic  addr_strap_b_gpio_drv, addr_strap_b_gpio_oe, bclk_pin_drv, bclk_pin_oe, sync_pin_drv, sync_pin_oe;
  wire logic  serial_tx_a_pin_drv, serial_tx_a_pin_oe, serial_tx_b_pin_drv, serial_tx_b_pin_oe;
  wire logic  serial_rx_a_pin_drv, serial_rx_a_pin_oe, chip_reset, serial_rx_a, serial_rx_b;
  wire logic  mic_stream_in_a, mic_bit_clock_out, host_bclk, host_sync;
  wire logic [1:0] i2c_addr_sel;
  wire logic [3:0] gpio_in;
  wire logic  link_clk              = bclk_pin_oe ? bclk_pin_drv : host_bclk;
  wire logic  sync_pin_lvl          = sync_pin_oe ? sync_pin_drv : host_sync;
  wire logic  addr_strap_a_gpio_lvl = strap_a;
  wire logic  addr_strap_b_gpio_lvl = addr_strap_b_gpio_oe ? addr_strap_b_gpio_drv : ext[0];
  wire logic  serial_tx_a_pin_lvl   = serial_tx_a_pin_oe ? serial_tx_a_pin_drv : ext[1];
  wire logic  serial_tx_b_pin_lvl   = serial_tx_b_pin_oe ? serial_tx_b_pin_drv : ext[2];
  wire logic  serial_rx_a_pin_lvl   = serial_rx_a_pin_oe ? serial_rx_a_pin_drv : ext[3];
  wire logic [3:0] oe_got  = {serial_rx_a_pin_oe, serial_tx_b_pin_oe, serial_tx_a_pin_oe, addr_strap_b_gpio_oe};
  wire logic [3:0] drv_got = {serial_rx_a_pin_drv, serial_tx_b_pin_drv, serial_tx_a_pin_drv, addr_strap_b_gpio_drv};
  wire logic [5:0] all_oe  = {oe_got, bclk_pin_oe, sync_pin_oe};

  apm_pin_mux #(.SYNC_LOSS_CYC(16'h00C8)) apm_pin_mux_i (
    .core_clk, .rst_n, .core_ce(1'b1), .link_clk, .supply_low, .addr_strap_a_gpio_lvl, .addr_strap_b_gpio_lvl,
    .addr_strap_b_gpio_drv, .addr_strap_b_gpio_oe, .bclk_pin_drv, .bclk_pin_oe, .sync_pin_lvl, .sync_pin_drv,
    .sync_pin_oe, .serial_tx_a_pin_lvl, .serial_tx_a_pin_drv, .serial_tx_a_pin_oe, .serial_tx_b_pin_lvl,
    .serial_tx_b_pin_drv, .serial_tx_b_pin_oe, .serial_rx_a_pin_lvl, .serial_rx_a_pin_drv, .serial_rx_a_pin_oe,
    .node_is_sub, .cfg_load, .tx_a_en, .tx_b_en, .rx_b_alt_en, .rx_a_en, .mic_in_en, .bclk_mic_sel, .clkout_b_en,
    .clkout_b_half, .gpio_oe, .gpio_out, .serial_tx_a, .serial_tx_b, .i2c_addr_sel, .chip_reset, .gpio_in,
    .serial_rx_a, .serial_rx_b, .mic_stream_in_a, .mic_bit_clock_out);

  apm_host_model apm_host_model_i (.run(run), .bclk(host_bclk), .sync(host_sync));

  always #50 core_clk = ~core_clk;
  always @(posedge mic_bit_clock_out) mic_edges++;
  always @(posedge bclk_pin_drv) bclk_edges++;
  always @(posedge addr_strap_b_gpio_drv) sb_edges++;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic go_active();
    int n;
    n = 0;
    while (chip_reset !== 1'b0 && n < 2000) begin
      cyc(1);
      n++;
    end
    cfg_load = 1'b1;
    cyc(2);
    cfg_load = 1'b0;
    cyc(2);
  endtask : go_active

  // Expected {oe, masked drv, drv mask} of strap b, tx a, tx b, rx a
  function automatic logic [11:0] exp_pins();
    logic [3:0] oe, drv, m;
    oe  = {gpio_oe[3] & ~(rx_a_en | mic_in_en), tx_b_en | (gpio_oe[2] & ~rx_b_alt_en), tx_a_en | gpio_oe[1],
           clkout_b_en | gpio_oe[0]};
    drv = {gpio_out[3], tx_b_en ? serial_tx_b : gpio_out[2], tx_a_en ? serial_tx_a : gpio_out[1], gpio_out[0]};
    m   = oe & {3'h7, ~clkout_b_en};
    return {oe, drv & m, m};
  endfunction : exp_pins

  initial begin
    logic [31:0] r;
    logic [11:0] e;
    logic [3:0]  lvl, gm;
    int          d, b0, m0;
    cyc(2);
    tx_a_en = 1'b1;
    gpio_oe = 4'hF;
    for (int k = 0; k < 4; k++) begin
      {ext[0], strap_a} = 2'(k);
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(10);
      `CHK(i2c_addr_sel, 2'(k))
      `CHK(all_oe, 6'h00)
      `CHK(addr_strap_b_gpio_oe, 1'b0)
    end
    $display("test done: straps and reset");
    go_active();
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      {tx_a_en, tx_b_en, rx_b_alt_en, rx_a_en, clkout_b_en, serial_tx_a, serial_tx_b} = r[6:0];
      mic_in_en = r[7] & ~r[3];
      {gpio_oe, gpio_out, ext} = r[19:8];
      if (i == 0)
        {tx_a_en, tx_b_en, rx_b_alt_en, rx_a_en, mic_in_en, clkout_b_en, gpio_oe} = {6'h00, 4'hF};
      if (i == 1)
        {tx_b_en, rx_b_alt_en, gpio_oe} = {2'h3, 4'hF};
      cyc(5);
      e   = exp_pins();
      lvl = (e[7:4] & e[11:8]) | (ext & ~e[11:8]);
      gm  = ~(e[11:8] & ~e[3:0]);
      `CHK({oe_got, bclk_pin_oe, sync_pin_oe}, {e[11:8], 2'h0})
      `CHK(drv_got & e[3:0], e[7:4])
      `CHK(gpio_in & gm, lvl & gm)
      `CHK({serial_rx_a, mic_stream_in_a, serial_rx_b}, {rx_a_en & ext[3], mic_in_en & ext[3], rx_b_alt_en & ~tx_b_en & ext[2]})
    end
    $display("test done: random pin functions");
    {clkout_b_en, gpio_oe, clkout_b_half, mic_in_en, rx_a_en} = {1'b1, 4'h0, 4'h3, 2'h2};
    cyc(4);
    d = sb_edges;
    cyc(80);
    d = sb_edges - d;
    `CHK(d >= 9 && d <= 11, 1'b1)
    $display("test done: aux clock output");
    cyc(400);
    @(posedge host_sync);
    m0 = mic_edges;
    repeat (4) @(posedge host_sync);
    d = mic_edges - m0;
    `CHK(d >= 253 && d <= 259, 1'b1)
    cyc(1);
    $display("test done: mic clock rate");
    gpio_oe = 4'hF;
    tx_a_en = 1'b1;
    @(negedge host_sync);
    #500;
    run = 1'b0;
    cyc(150);
    `CHK(chip_reset, 1'b0)
    cyc(100);
    `CHK(chip_reset, 1'b1)
    `CHK(all_oe, 6'h00)
    run = 1'b1;
    go_active();
    `CHK(serial_tx_a_pin_oe, 1'b1)
    $display("test done: frame sync loss");
    supply_low = 1'b1;
    cyc(5);
    `CHK({chip_reset, all_oe}, 7'h40)
    supply_low = 1'b0;
    go_active();
    $display("test done: low supply");
    {run, node_is_sub, mic_in_en, bclk_mic_sel} = 4'h4;
    cyc(4);
    `CHK({bclk_pin_oe, sync_pin_oe}, 2'h3)
    b0 = bclk_edges;
    cyc(400);
    d = bclk_edges - b0;
    `CHK(d >= 99 && d <= 101, 1'b1)
    `CHK(chip_reset, 1'b0)
    {mic_in_en, bclk_mic_sel} = 2'h3;
    cyc(4);
    b0 = bclk_edges;
    m0 = mic_edges;
    cyc(600);
    d = (bclk_edges - b0) - (mic_edges - m0);
    `CHK(d >= -2 && d <= 2, 1'b1)
    `CHK(mic_edges - m0 > 0, 1'b1)
    d = 0;
    while (sync_pin_drv !== 1'b1 && d < 2100) begin
      cyc(1);
      d++;
    end
    cyc(3);
    `CHK(sync_pin_drv, 1'b1)
    cyc(1);
    `CHK({sync_pin_drv, d < 2100}, 2'h1)
    $display("test done: subordinate node");
    wrap_up();
  end
endmodule : tb_top
